// File: bench/test_stepper_chopper_control.sv
// Self-checking bench of the stepper chopper control with its winding model.
`timescale 1ns/1ps
module test_stepper_chopper_control
  import chop_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, cur_hit, thr_hit;
  logic        hreadyout, hresp, step_clk = 1'b0, angle_reset = 1'b1;
  logic        tq_msb = 1'b0, tq_lsb = 1'b0, osc_pin = 1'b0;
  logic        thermal = 1'b0, ovc = 1'b0, stall = 1'b0;
  logic [7:0]  thr_dly = 8'h02;
  gate_t       gate_a, gate_b, prev_a, last_nz = gate_t'(4'h0);
  logic [6:0]  target_a, target_b;
  logic        ang_o, ang_oe_n, any_o, any_oe_n, thm_o, thm_oe_n;
  int          miscompares = 0, checks_done = 0, cyc = 0, start_t = 0, period = 0;
  int          fast_len = 0, run = 0, off_run = 99, d, e, p;

  always #12.5 hclk = ~hclk;

  stepper_chopper_control u_stepper_chopper_control (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .step_clk(step_clk), .angle_reset(angle_reset),
    .torque_sel_msb(tq_msb), .torque_sel_lsb(tq_lsb), .chop_osc_setting_pin(osc_pin),
    .current_reached(cur_hit), .adaptive_decay_threshold(thr_hit),
    .thermal_shutdown(thermal), .overcurrent_shutdown(ovc), .gate_a(gate_a),
    .gate_b(gate_b), .target_a(target_a), .target_b(target_b),
    .initial_angle_flag_i(ang_oe_n | ang_o), .initial_angle_flag_o(ang_o),
    .initial_angle_flag_oe_n(ang_oe_n), .fault_flag_any_i(any_oe_n | any_o),
    .fault_flag_any_o(any_o), .fault_flag_any_oe_n(any_oe_n),
    .fault_flag_thermal_i(thm_oe_n | thm_o), .fault_flag_thermal_o(thm_o),
    .fault_flag_thermal_oe_n(thm_oe_n));

  winding_model u_winding_model (
    .hclk(hclk), .hresetn(hresetn), .stall(stall), .thr_dly(thr_dly), .gate_a(gate_a),
    .gate_b(gate_b), .cur_hit(cur_hit), .thr_hit(thr_hit));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
    rd = hrdata;
    if (n >= 40) begin
      miscompares++;
      final_report();
    end
  endtask : bus

  task automatic step();
    step_clk <= 1'b1;
    wt(4);
    step_clk <= 1'b0;
    wt(8);
  endtask : step

  function automatic logic [6:0] exp_tgt(input int r, input int tq);
    int pct [4] = '{100, 75, 50, 25};
    return 7'(((r < 2) ? 100 : 71) * pct[tq] / 100);
  endfunction : exp_tgt

  // ==========================================================
  // Gate watcher: legal patterns, dead interval, chop period and fast length.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    prev_a <= gate_a;
    run <= (gate_a == prev_a) ? run + 1 : 1;
    off_run <= (gate_a == 4'h0) ? off_run + 1 : 0;
    if (!(gate_a inside {4'h0, 4'h3, 4'h6, 4'h9})) chk(gate_a, 4'h3);
    if (prev_a == 4'h6 && gate_a != 4'h6) fast_len <= run;
    if (gate_a == 4'h9 && prev_a != 4'h9) begin
      period <= cyc - start_t;
      start_t <= cyc;
    end
    if (gate_a != 4'h0) begin
      last_nz <= gate_a;
      if (gate_a != last_nz && last_nz != 4'h0 && off_run <= int'(DEAD_CYC))
        chk(off_run, DEAD_CYC + 1);
    end
  end

  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    final_report();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'h0a18));
    wt(2);
    hresetn <= 1'b1;
    wt(4);
    chk(ang_oe_n, 1'b0);
    chk({any_oe_n, thm_oe_n}, 2'h3);
    chk({hresp, ang_o, any_o, thm_o}, 4'h0);
    bus(0, A_OSCDIV, 0);
    chk(rd, 32'h2b);
    bus(0, 8'h20, 0);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 7; r++) begin
      for (int tq = 0; tq < 4; tq++) begin
        bus(1, A_CTRL, 32'(r) << 1);
        {tq_msb, tq_lsb} <= 2'(tq);
        wt(8);
        bus(0, A_TARGET, 0);
        chk(rd, {14'h0, 2'(tq), 1'b0, exp_tgt(r, tq), 1'b0, exp_tgt(r, tq)});
        chk({target_b, target_a}, {exp_tgt(r, tq), exp_tgt(r, tq)});
      end
    end
    $display("test torque done");
    bus(1, A_CTRL, 0);
    {tq_msb, tq_lsb} <= 2'h0;
    stall <= 1'b1;
    wt(1600);
    chk({gate_a, gate_b}, 8'h99);
    angle_reset <= 1'b0;
    wt(4);
    step();
    bus(0, A_STATUS, 0);
    chk(rd[6:0], 7'h30);
    chk(ang_oe_n, 1'b1);
    wt(1600);
    chk({gate_a, gate_b}, 8'h69);
    bus(1, A_CTRL, 32'h18);
    step();
    bus(0, A_STATUS, 0);
    chk(rd[6:0], 7'h2c);
    angle_reset <= 1'b1;
    wt(8);
    step();
    chk(ang_oe_n, 1'b0);
    bus(0, A_STATUS, 0);
    chk(rd[6:0], 7'h10);
    $display("test angle done");
    stall <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      d = 10 + $urandom % 40;
      bus(1, A_OSCDIV, 32'(d));
      osc_pin <= (i != 0);
      p = (i == 0) ? int'(OSC_DIV) : d;
      e = 16 * p;
      wt(3 * e + 100);
      chk(period, e);
      chk(fast_len >= p - 8 && fast_len <= 2 * p, 1'b1);
    end
    $display("test chop done");
    thermal <= 1'b1;
    wt(6);
    thermal <= 1'b0;
    wt(200);
    chk({any_oe_n, thm_oe_n, gate_a, gate_b}, 10'h0);
    bus(0, A_STATUS, 0);
    chk(rd[16:14], 3'h0);
    bus(1, A_CTRL, 1);
    bus(1, A_CTRL, 0);
    wt(6);
    chk({any_oe_n, thm_oe_n}, 2'h3);
    ovc <= 1'b1;
    wt(6);
    ovc <= 1'b0;
    wt(8);
    chk({any_oe_n, thm_oe_n, gate_a}, 6'h10);
    hresetn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    wt(4);
    chk({any_oe_n, thm_oe_n, ang_oe_n}, 3'h6);
    $display("test fault done");
    final_report();
  end
endmodule : test_stepper_chopper_control

// File: bench/winding_model.sv
// Winding model that answers the bridge gates of both channels.
`timescale 1ns/1ps
module winding_model
  import chop_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       stall,
  input  wire logic [7:0] thr_dly,
  input  gate_t           gate_a,
  input  gate_t           gate_b,
  output logic      [1:0] cur_hit,
  output logic      [1:0] thr_hit
);
  gate_t      g       [2];
  gate_t      prev_ff [2];
  logic [7:0] run_ff  [2];

  assign g[0] = gate_a;
  assign g[1] = gate_b;

  // ==========================================================
  // Supply current rises in forward charge 1001, regenerated current shows in forward fast decay 0110.
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 2; i++) begin
      if (!hresetn) begin
        prev_ff[i] <= gate_t'(4'h0);
        run_ff[i]  <= 8'h00;
        cur_hit[i] <= 1'b0;
        thr_hit[i] <= 1'b0;
      end else begin
        prev_ff[i] <= g[i];
        run_ff[i]  <= (g[i] != prev_ff[i]) ? 8'h00 : run_ff[i] + 8'(run_ff[i] != 8'hff);
        if (g[i] == 4'h9 && run_ff[i] >= 8'h14 && !stall) begin
          cur_hit[i] <= 1'b1;
        end else if (g[i] == 4'h3) begin
          cur_hit[i] <= 1'b0;
        end
        thr_hit[i] <= !stall && g[i] == 4'h6 && run_ff[i] >= thr_dly;
      end
    end
  end
endmodule : winding_model

// File: rtl/chop_channel.sv
// One bridge channel: decay phase sequencer with blanking and dead time.
`timescale 1ns/1ps
module chop_channel
  import chop_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic osc_tick,
  input  wire logic cyc_start,
  input  wire logic cur_reached,
  input  wire logic decay_thr,
  input  wire logic reverse,
  input  wire logic kill,
  output gate_t     gate,
  output phase_t    phase
);
  phase_t     phase_ff, nxt_phase;
  logic [3:0] cnt_ff, nxt_cnt, dead_ff, nxt_dead;
  logic       seen_ff, nxt_seen, blanking;
  gate_t      gate_ff, nxt_gate, want;

  //==========================================================
  // Decay phase sequence.
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_seen = seen_ff;
    blanking = (cnt_ff < BLANK_OSC);
    if (kill) begin
      nxt_phase = PH_CHARGE;
      nxt_cnt = 4'h0;
      nxt_seen = 1'b0;
    end else if (cyc_start) begin
      nxt_phase = PH_CHARGE; // RULE1 RULE4
    end else begin
      unique case (phase_ff)
        PH_CHARGE: begin
          if (cur_reached) begin // RULE2 RULE4
            nxt_phase = PH_FAST;
            nxt_cnt = 4'h0;
            nxt_seen = 1'b0;
          end
        end
        PH_FAST: begin
          if (osc_tick) nxt_cnt = 4'(cnt_ff + 4'h1);
          if (decay_thr && blanking) nxt_seen = 1'b1; // RULE3
          if ((decay_thr || seen_ff) && !blanking) nxt_phase = PH_SLOW; // RULE2 RULE3
          else if (cnt_ff == FAST_OSC) nxt_phase = PH_SLOW;
        end
        PH_SLOW: nxt_phase = PH_SLOW;
        default: nxt_phase = PH_CHARGE;
      endcase
    end
  end

  //==========================================================
  // Bridge pattern with a dead interval between patterns.
  always_comb begin
    want = gate_of(phase_ff, reverse); // RULE12 RULE13
    nxt_gate = gate_ff;
    nxt_dead = (dead_ff != 4'h0) ? 4'(dead_ff - 4'h1) : dead_ff;
    if (kill || (want != gate_ff && gate_ff != GATE_OFF)) begin
      nxt_gate = GATE_OFF; // RULE14 RULE16
      nxt_dead = DEAD_CYC;
    end else if (want != gate_ff && dead_ff == 4'h0) begin
      nxt_gate = want;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= PH_CHARGE;
      cnt_ff <= 4'h0;
      seen_ff <= 1'b0;
      gate_ff <= GATE_OFF;
      dead_ff <= 4'h0;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      seen_ff <= nxt_seen;
      gate_ff <= nxt_gate;
      dead_ff <= nxt_dead;
    end
  end

  assign gate = gate_ff;
  assign phase = phase_ff;

  //==========================================================
  // Checks.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  dead_gap_a: assert property ($fell(gate_ff != GATE_OFF) |-> (gate_ff == GATE_OFF) [*4]) // RULE14
    else $error("Bridge pattern applied inside the dead interval.");
  kill_off_a: assert property (kill |=> gate_ff == GATE_OFF) // RULE16
    else $error("Bridge not off while killed.");
  long_chg_a: assert property (phase_ff == PH_CHARGE && !cur_reached && !kill
    |=> phase_ff == PH_CHARGE) // RULE4
    else $error("Charge left before current reached.");
  blank_slow_a: assert property (phase_ff == PH_FAST && seen_ff && !blanking
    && !cyc_start && !kill |=> phase_ff == PH_SLOW) // RULE3
    else $error("No slow decay after blanking.");
  fast_slow_c: cover property (phase_ff == PH_FAST ##1 phase_ff == PH_SLOW);
  carry_chg_c: cover property (cyc_start && phase_ff == PH_CHARGE && !kill);
endmodule : chop_channel

// File: rtl/stepper_chopper_control.sv
// Top of the stepper chopper control: bus slave, pins, angle, torque and faults.
`timescale 1ns/1ps
//==========================================================
// What this block does
// (RULE1) A chopping cycle is 16 oscillator clocks and holds all decay phases.
// (RULE2) Decay choice uses both supply current and regenerated current.
// (RULE3) A decay threshold seen in blanking moves to slow decay after blanking.
// (RULE4) A charge that outlasts the cycle carries on until current is reached.
// (RULE5) A high angle reset pin holds the angle at its initial value.
// (RULE6) At the initial angle full and half (a) give 100%, others 71%.
// (RULE7) Torque pins scale the target to 100, 75, 50 or 25 percent.
// (RULE8) The angle flag pin is pulled low only at the initial angle.
// (RULE9) The general fault pin pulls low after a thermal or over-current trip.
// (RULE10) The thermal fault pin pulls low only after a thermal trip.
// (RULE11) Fault flags stay latched until power cycle or a sleep period.
// (RULE12) Forward current uses charge 1001, fast 0110, slow 0011.
// (RULE13) Reverse current swaps charge and fast, slow stays 0011.
// (RULE14) Every pattern change passes through an all off dead interval.
// (RULE15) With the setting pin low the oscillator runs at the nominal rate.
// (RULE16) A fault forces every bridge switch off while it stays latched.
// (RULE17) Each target is the step table percent times the torque percent.
module stepper_chopper_control
  import chop_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        step_clk,
  input  wire logic        angle_reset,
  input  wire logic        torque_sel_msb,
  input  wire logic        torque_sel_lsb,
  input  wire logic        chop_osc_setting_pin,
  input  wire logic [1:0]  current_reached,
  input  wire logic [1:0]  adaptive_decay_threshold,
  input  wire logic        thermal_shutdown,
  input  wire logic        overcurrent_shutdown,
  output gate_t            gate_a,
  output gate_t            gate_b,
  output logic      [6:0]  target_a,
  output logic      [6:0]  target_b,
  input  wire logic        initial_angle_flag_i,
  output logic             initial_angle_flag_o,
  output logic             initial_angle_flag_oe_n,
  input  wire logic        fault_flag_any_i,
  output logic             fault_flag_any_o,
  output logic             fault_flag_any_oe_n,
  input  wire logic        fault_flag_thermal_i,
  output logic             fault_flag_thermal_o,
  output logic             fault_flag_thermal_oe_n
);
  pins_t       raw, sync1_ff, sync2_ff;
  ctrl_t       ctrl_ff, nxt_ctrl;
  logic [7:0]  oscdiv_ff, nxt_oscdiv, osc_cnt_ff, nxt_osc_cnt, osc_div;
  logic [3:0]  chop_ff, nxt_chop;
  logic        osc_tick_ff, nxt_osc_tick, cyc_ff, nxt_cyc;
  logic [6:0]  angle_ff, nxt_angle;
  logic        step_prev_ff, step_edge;
  logic [7:0]  cos_a, sin_b;
  target_t     tgt_ff, nxt_tgt;
  logic        thermal_ff, nxt_thermal, ovc_ff, nxt_ovc, kill;
  logic        any_oe_n_ff, thr_oe_n_ff, init_oe_n_ff, zero_ff;
  logic        wr_ff, nxt_wr, rd_ff, nxt_rd, rdy_ff, nxt_rdy;
  logic [7:0]  addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata, rd_word;
  status_t     st;
  gate_t       ga, gb;
  phase_t      pa, pb;

  //==========================================================
  // Pin synchronisers.
  assign raw = {step_clk, angle_reset, torque_sel_msb, torque_sel_lsb,
                chop_osc_setting_pin, current_reached, adaptive_decay_threshold,
                thermal_shutdown, overcurrent_shutdown,
                initial_angle_flag_i, fault_flag_any_i, fault_flag_thermal_i};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  //==========================================================
  // Chopping oscillator and cycle counter.
  always_comb begin
    osc_div = sync2_ff.osc_pin ? oscdiv_ff : OSC_DIV; // RULE15
    nxt_osc_tick = (osc_cnt_ff >= 8'(osc_div - 8'h01));
    nxt_osc_cnt = nxt_osc_tick ? 8'h00 : 8'(osc_cnt_ff + 8'h01);
    nxt_chop = nxt_osc_tick ? 4'(chop_ff + 4'h1) : chop_ff; // RULE1
    nxt_cyc = nxt_osc_tick && (chop_ff == CHOP_LAST); // RULE1
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_ff <= 8'h00;
      chop_ff <= 4'h0;
      osc_tick_ff <= 1'b0;
      cyc_ff <= 1'b0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      chop_ff <= nxt_chop;
      osc_tick_ff <= nxt_osc_tick;
      cyc_ff <= nxt_cyc;
    end
  end

  //==========================================================
  // Electrical angle and current targets.
  always_comb begin
    step_edge = sync2_ff.step_clk && !step_prev_ff;
    nxt_angle = angle_ff;
    if (sync2_ff.angle_reset) begin
      nxt_angle = ANGLE_INIT; // RULE5
    end else if (step_edge && !ctrl_ff.sleep) begin
      if (ctrl_ff.dir_rev) nxt_angle = 7'(angle_ff - step_inc(ctrl_ff.res));
      else nxt_angle = 7'(angle_ff + step_inc(ctrl_ff.res));
    end
    cos_a = sine_of(7'(angle_ff + 7'h20));
    sin_b = sine_of(angle_ff);
    nxt_tgt.torque = {sync2_ff.torque_sel_msb, sync2_ff.torque_sel_lsb};
    nxt_tgt.rev_a = cos_a[7];
    nxt_tgt.rev_b = sin_b[7];
    nxt_tgt.tgt_a = eff_target(ctrl_ff.res, cos_a[6:0], nxt_tgt.torque); // RULE6 RULE7 RULE17
    nxt_tgt.tgt_b = eff_target(ctrl_ff.res, sin_b[6:0], nxt_tgt.torque); // RULE6 RULE7 RULE17
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      angle_ff <= ANGLE_INIT;
      step_prev_ff <= 1'b0;
      tgt_ff <= '0;
    end else begin
      angle_ff <= nxt_angle;
      step_prev_ff <= sync2_ff.step_clk;
      tgt_ff <= nxt_tgt;
    end
  end

  //==========================================================
  // Fault latches and open-drain flags.
  always_comb begin
    nxt_thermal = sync2_ff.thermal || (thermal_ff && !ctrl_ff.sleep); // RULE11
    nxt_ovc = sync2_ff.overcurrent || (ovc_ff && !ctrl_ff.sleep); // RULE11
    kill = thermal_ff || ovc_ff || ctrl_ff.sleep; // RULE16
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thermal_ff <= 1'b0;
      ovc_ff <= 1'b0;
      any_oe_n_ff <= 1'b1;
      thr_oe_n_ff <= 1'b1;
      init_oe_n_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      thermal_ff <= nxt_thermal;
      ovc_ff <= nxt_ovc;
      any_oe_n_ff <= !(nxt_thermal || nxt_ovc); // RULE9
      thr_oe_n_ff <= !nxt_thermal; // RULE10
      init_oe_n_ff <= (nxt_angle != ANGLE_INIT); // RULE8
      zero_ff <= 1'b0;
    end
  end

  //==========================================================
  // Bus slave and control registers.
  always_comb begin
    st.flag_lvl = sync2_ff.flag_lvl;
    st.at_init = (angle_ff == ANGLE_INIT);
    st.ovc = ovc_ff;
    st.thermal = thermal_ff;
    st.ph_b = pb;
    st.ph_a = pa;
    st.angle = angle_ff;
    case (addr_ff)
      A_CTRL:   rd_word = 32'(ctrl_ff);
      A_OSCDIV: rd_word = 32'(oscdiv_ff);
      A_STATUS: rd_word = 32'(st);
      A_TARGET: rd_word = 32'(tgt_ff);
      default:  rd_word = 32'h0000_0000;
    endcase
    nxt_wr = hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
    nxt_rd = hsel && hready && htrans[1] && !hwrite;
    nxt_addr = (hsel && hready && htrans[1]) ? haddr[7:0] : addr_ff;
    nxt_rdy = !nxt_rd;
    nxt_rdata = rd_ff ? rd_word : rdata_ff;
    nxt_ctrl = ctrl_ff;
    nxt_oscdiv = oscdiv_ff;
    if (wr_ff && addr_ff == A_CTRL) nxt_ctrl = ctrl_t'(hwdata[4:0]);
    if (wr_ff && addr_ff == A_OSCDIV) nxt_oscdiv = hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      rdy_ff <= 1'b1;
      addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= ctrl_t'(CTRL_RST);
      oscdiv_ff <= OSC_DIV;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      rdy_ff <= nxt_rdy;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      oscdiv_ff <= nxt_oscdiv;
    end
  end

  //==========================================================
  // Bridge channels.
  chop_channel u_ch_a (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .osc_tick    (osc_tick_ff),
    .cyc_start   (cyc_ff),
    .cur_reached (sync2_ff.current_reached[0]),
    .decay_thr   (sync2_ff.decay_thr[0]),
    .reverse     (tgt_ff.rev_a),
    .kill        (kill),
    .gate        (ga),
    .phase       (pa)
  );

  chop_channel u_ch_b (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .osc_tick    (osc_tick_ff),
    .cyc_start   (cyc_ff),
    .cur_reached (sync2_ff.current_reached[1]),
    .decay_thr   (sync2_ff.decay_thr[1]),
    .reverse     (tgt_ff.rev_b),
    .kill        (kill),
    .gate        (gb),
    .phase       (pb)
  );

  assign gate_a = ga;
  assign gate_b = gb;
  assign target_a = tgt_ff.tgt_a;
  assign target_b = tgt_ff.tgt_b;
  assign hrdata = rdata_ff;
  assign hreadyout = rdy_ff;
  assign hresp = zero_ff;
  assign initial_angle_flag_o = zero_ff;
  assign initial_angle_flag_oe_n = init_oe_n_ff;
  assign fault_flag_any_o = zero_ff;
  assign fault_flag_any_oe_n = any_oe_n_ff;
  assign fault_flag_thermal_o = zero_ff;
  assign fault_flag_thermal_oe_n = thr_oe_n_ff;

  //==========================================================
  // Checks.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chop_wrap_a: assert property (cyc_ff |-> osc_tick_ff && chop_ff == 4'h0) // RULE1
    else $error("Chopping cycle does not start at count zero.");
  osc_rate_a: assert property (osc_tick_ff && !sync2_ff.osc_pin
    |=> !osc_tick_ff [*8]) // RULE15
    else $error("Internal oscillator ticks too fast.");
  angle_rst_a: assert property (sync2_ff.angle_reset |=> angle_ff == ANGLE_INIT) // RULE5
    else $error("Angle not held at its initial value.");
  init_full_a: assert property (angle_ff == ANGLE_INIT && ctrl_ff.res == RES_FULL
    && nxt_tgt.torque == 2'h0 |=> tgt_ff.tgt_a == 7'h64 && tgt_ff.tgt_b == 7'h64) // RULE6
    else $error("Full step initial current is not 100 percent.");
  init_fine_a: assert property (angle_ff == ANGLE_INIT && ctrl_ff.res == RES_32
    && nxt_tgt.torque == 2'h0 |=> tgt_ff.tgt_a == 7'h47 && tgt_ff.tgt_b == 7'h47) // RULE6
    else $error("Fine step initial current is not 71 percent.");
  torque_qtr_a: assert property (angle_ff == ANGLE_INIT && ctrl_ff.res == RES_FULL
    && nxt_tgt.torque == 2'h3 |=> tgt_ff.tgt_a == 7'h19) // RULE7
    else $error("Quarter torque not applied.");
  init_flag_a: assert property ((angle_ff == ANGLE_INIT) == !init_oe_n_ff) // RULE8
    else $error("Angle flag disagrees with the angle.");
  ovc_flag_a: assert property (sync2_ff.overcurrent |=> !any_oe_n_ff && ovc_ff) // RULE9
    else $error("Over-current did not pull the fault flag.");
  thr_only_a: assert property (!thermal_ff |-> thr_oe_n_ff) // RULE10
    else $error("Thermal flag driven without a thermal trip.");
  latch_hold_a: assert property (ovc_ff && !ctrl_ff.sleep |=> ovc_ff) // RULE11
    else $error("Fault latch released without sleep.");
  fault_off_a: assert property (thermal_ff || ovc_ff
    |=> ga == GATE_OFF && gb == GATE_OFF) // RULE16
    else $error("Bridge left on during a fault.");
  fault_c: cover property (ovc_ff ##1 ctrl_ff.sleep ##1 !ovc_ff);
  thermal_c: cover property (!thr_oe_n_ff && !any_oe_n_ff);
  rev_chg_c: cover property (tgt_ff.rev_a && ga == GATE_FST);
endmodule : stepper_chopper_control

// File: shared/chop_pkg.sv
// Constants, carrier types and lookup functions of the stepper chopper control.
package chop_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned OSC_HZ = 914000;
  localparam logic [7:0] OSC_DIV = 8'(CLK_HZ / OSC_HZ);
  localparam logic [3:0] CHOP_LAST = 4'hf;
  localparam logic [3:0] FAST_OSC = 4'h6;
  localparam logic [3:0] BLANK_OSC = 4'h2;
  localparam int unsigned DEAD_NS = 100;
  localparam logic [3:0] DEAD_CYC = 4'((DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000);
  localparam logic [6:0] ANGLE_INIT = 7'h10;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OSCDIV = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_TARGET = 8'h0c;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_CHG = 4'h9;
  localparam logic [3:0] GATE_FST = 4'h6;
  localparam logic [3:0] GATE_SLW = 4'h3;
  localparam logic [32:0][6:0] SINE_Q = {
    7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5e, 7'h5c, 7'h5a, 7'h58,
    7'h56, 7'h53, 7'h50, 7'h4d, 7'h4a, 7'h47, 7'h43, 7'h3f, 7'h3c, 7'h38, 7'h33,
    7'h2f, 7'h2b, 7'h26, 7'h22, 7'h1d, 7'h18, 7'h14, 7'h0f, 7'h0a, 7'h05, 7'h00};

  typedef enum logic [1:0] {
    PH_CHARGE = 2'b00, PH_FAST = 2'b01, PH_SLOW = 2'b10
  } phase_t;
  typedef enum logic [2:0] {
    RES_FULL = 3'b000, RES_HALF_A = 3'b001, RES_HALF_B = 3'b010,
    RES_QUARTER = 3'b011, RES_8 = 3'b100, RES_16 = 3'b101, RES_32 = 3'b110
  } res_t;
  typedef struct packed {
    logic high_side_switch_a;
    logic high_side_switch_b;
    logic low_side_switch_a;
    logic low_side_switch_b;
  } gate_t;
  typedef struct packed {logic dir_rev; res_t res; logic sleep;} ctrl_t;
  typedef struct packed {
    logic step_clk; logic angle_reset; logic torque_sel_msb; logic torque_sel_lsb;
    logic osc_pin; logic [1:0] current_reached; logic [1:0] decay_thr;
    logic thermal; logic overcurrent; logic [2:0] flag_lvl;
  } pins_t;
  typedef struct packed {
    logic [2:0] flag_lvl; logic at_init; logic ovc; logic thermal;
    phase_t ph_b; phase_t ph_a; logic [6:0] angle;
  } status_t;
  typedef struct packed {
    logic [1:0] torque; logic rev_b; logic [6:0] tgt_b; logic rev_a; logic [6:0] tgt_a;
  } target_t;

  function automatic gate_t gate_of(input phase_t ph, input logic rev);
    case (ph)
      PH_CHARGE: return gate_t'(rev ? GATE_FST : GATE_CHG);
      PH_FAST:   return gate_t'(rev ? GATE_CHG : GATE_FST);
      PH_SLOW:   return gate_t'(GATE_SLW);
      default:   return gate_t'(GATE_OFF);
    endcase
  endfunction : gate_of

  // Returns sign and magnitude in percent of the sine of a 128-step angle.
  function automatic logic [7:0] sine_of(input logic [6:0] ang);
    logic [5:0] p;
    logic [6:0] m;
    p = ang[5] ? 6'(6'h20 - {1'b0, ang[4:0]}) : {1'b0, ang[4:0]};
    m = SINE_Q[p];
    return {ang[6] && (m != 7'h00), m};
  endfunction : sine_of

  function automatic logic [6:0] step_inc(input res_t r);
    case (r)
      RES_FULL:                return 7'h20;
      RES_HALF_A, RES_HALF_B:  return 7'h10;
      RES_QUARTER:             return 7'h08;
      RES_8:                   return 7'h04;
      RES_16:                  return 7'h02;
      default:                 return 7'h01;
    endcase
  endfunction : step_inc

  function automatic logic [6:0] eff_target(input res_t r, input logic [6:0] m,
                                            input logic [1:0] tq);
    logic [6:0]  pm;
    logic [6:0]  tp;
    pm = ((r == RES_FULL || r == RES_HALF_A) && m != 7'h00) ? PCT_FULL : m;
    tp = (tq == 2'h0) ? 7'h64 : (tq == 2'h1) ? 7'h4b : (tq == 2'h2) ? 7'h32 : 7'h19;
    return 7'((14'(pm) * 14'(tp)) / 14'h0064);
  endfunction : eff_target
endpackage : chop_pkg
